/* File: hw/cttsw_core.v */
// Purpose: Execute unit for trap, wait, zero test and register transfers.
// Assumes: MEM_RDATA answers combinationally to the registered MEM_ADDR.
// Notes: One memory access per cycle; accesses are issued one cycle ahead.
`timescale 1ns/10ps
`include "cttsw_regs.vh"
module cttsw_core (
  input wire MCLK,
  input wire RST,
  input wire CE,
  input wire IRQ,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  output reg [15:0] MEM_ADDR,
  output reg MEM_RD,
  output reg MEM_WR,
  output reg [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  output wire CORE_CLK_EN
);
  reg [7:0] acc_q, x_q, h_q, flags_q, op_q, tmp_q;
  reg [15:0] sp_q, pc_q;
  reg [3:0] step_q;
  reg run_q, started_q, wait_q, ill_q;
  wire [15:0] hx = {h_q, x_q};
  wire [15:0] pc_inc = pc_q + 16'h0001;
  wire core_go = CE && run_q && started_q && !wait_q;
  wire neg, zero;
  reg [7:0] nz_src;

  ////////////////////////////////////////////////////////////////////////////
  // Bus access and flag helpers.
  always @* begin
    nz_src = MEM_RDATA;
    if (step_q == 4'd0 && MEM_RDATA == `CTTSW_OP_TSTA)
      nz_src = acc_q;
    else if (step_q == 4'd0 && MEM_RDATA == `CTTSW_OP_TSTX)
      nz_src = x_q;
  end

  cttsw_nz u_nz (
    .val(nz_src),
    .neg(neg),
    .zero(zero)
  );

  task issue;
    input [15:0] addr;
    input rd;
    input wr;
    input [7:0] data;
    begin
      MEM_ADDR <= addr;
      MEM_RD <= rd;
      MEM_WR <= wr;
      MEM_WDATA <= data;
    end
  endtask

  // Subtracting zero: V cleared, N and Z from the value, H, I and C kept.
  task test_flags;
    begin
      flags_q[`CTTSW_FLG_V] <= 1'b0;
      flags_q[`CTTSW_FLG_N] <= neg;
      flags_q[`CTTSW_FLG_Z] <= zero;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.
  wire apb_setup = PSEL && !PENABLE;
  wire apb_acc = PSEL && PENABLE;
  wire mapped = (PADDR[1:0] == 2'b00) && (PADDR <= `CTTSW_OFF_FLAGS);
  wire apb_wr = CE && apb_acc && PWRITE && mapped;
  wire cpu_wr = apb_wr && !run_q;
  assign PREADY = CE;
  assign PSLVERR = apb_acc && !mapped;
  assign CORE_CLK_EN = !wait_q;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (CE && apb_setup) begin
      case (PADDR)
        `CTTSW_OFF_CTRL: PRDATA <= {31'h00000000, run_q};
        `CTTSW_OFF_STAT: PRDATA <= {29'h00000000, step_q != 4'd0, ill_q, wait_q};
        `CTTSW_OFF_ACC: PRDATA <= {24'h000000, acc_q};
        `CTTSW_OFF_XLO: PRDATA <= {24'h000000, x_q};
        `CTTSW_OFF_XHI: PRDATA <= {24'h000000, h_q};
        `CTTSW_OFF_SP: PRDATA <= {16'h0000, sp_q};
        `CTTSW_OFF_PC: PRDATA <= {16'h0000, pc_q};
        `CTTSW_OFF_FLAGS: PRDATA <= {24'h000000, flags_q};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute sequencer.
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      acc_q <= `CTTSW_RST_ACC;
      x_q <= `CTTSW_RST_X;
      h_q <= `CTTSW_RST_H;
      sp_q <= `CTTSW_RST_SP;
      pc_q <= `CTTSW_RST_PC;
      flags_q <= `CTTSW_RST_FLAGS;
      op_q <= 8'h00;
      tmp_q <= 8'h00;
      step_q <= 4'd0;
      run_q <= 1'b0;
      started_q <= 1'b0;
      wait_q <= 1'b0;
      ill_q <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WDATA <= 8'h00;
    end else if (CE) begin
      if (apb_wr && PADDR == `CTTSW_OFF_CTRL)
        run_q <= PWDATA[`CTTSW_CTRL_RUN];
      if (apb_wr && PADDR == `CTTSW_OFF_STAT && PWDATA[`CTTSW_STAT_ILL])
        ill_q <= 1'b0;
      if (cpu_wr) begin
        case (PADDR)
          `CTTSW_OFF_ACC: acc_q <= PWDATA[7:0];
          `CTTSW_OFF_XLO: x_q <= PWDATA[7:0];
          `CTTSW_OFF_XHI: h_q <= PWDATA[7:0];
          `CTTSW_OFF_SP: sp_q <= PWDATA[15:0];
          `CTTSW_OFF_PC: pc_q <= PWDATA[15:0];
          `CTTSW_OFF_FLAGS: flags_q <= PWDATA[7:0] | `CTTSW_FLG_ONES;
          default: ;
        endcase
      end
      if (!run_q) begin
        started_q <= 1'b0;
        wait_q <= 1'b0;
        step_q <= 4'd0;
        issue(pc_q, 1'b0, 1'b0, 8'h00);
      end else if (!started_q) begin
        started_q <= 1'b1;
        issue(pc_q, 1'b1, 1'b0, 8'h00);
      end else if (wait_q) begin
        if (IRQ) begin
          wait_q <= 1'b0;
          issue(pc_q, 1'b1, 1'b0, 8'h00);
        end
      end else if (core_go) begin
        if (step_q == 4'd0) begin
          op_q <= MEM_RDATA;
          pc_q <= pc_inc;
          step_q <= 4'd1;
          case (MEM_RDATA)
            `CTTSW_OP_TRAP, `CTTSW_OP_A2F, `CTTSW_OP_S2X, `CTTSW_OP_X2S:
              issue(pc_inc, 1'b0, 1'b0, 8'h00);
            `CTTSW_OP_TSTD, `CTTSW_OP_TSTI1, `CTTSW_OP_PFX, `CTTSW_OP_LDAE:
              issue(pc_inc, 1'b1, 1'b0, 8'h00);
            `CTTSW_OP_TSTI:
              issue(hx, 1'b1, 1'b0, 8'h00);
            `CTTSW_OP_MOVPI: begin
              issue(hx, 1'b1, 1'b0, 8'h00);
              {h_q, x_q} <= hx + 16'h0001;
            end
            `CTTSW_OP_WAIT: begin
              flags_q[`CTTSW_FLG_I] <= 1'b0;
              wait_q <= 1'b1;
              step_q <= 4'd0;
              issue(pc_inc, 1'b0, 1'b0, 8'h00);
            end
            default: begin
              step_q <= 4'd0;
              issue(pc_inc, 1'b1, 1'b0, 8'h00);
              case (MEM_RDATA)
                `CTTSW_OP_TSTA, `CTTSW_OP_TSTX: test_flags;
                `CTTSW_OP_A2X: x_q <= acc_q;
                `CTTSW_OP_X2A: acc_q <= x_q;
                `CTTSW_OP_F2A: acc_q <= flags_q;
                default: ill_q <= 1'b1;
              endcase
            end
          endcase
        end else begin
          step_q <= step_q + 4'd1;
          case (op_q)
            `CTTSW_OP_A2F: begin
              flags_q <= acc_q | `CTTSW_FLG_ONES;
              step_q <= 4'd0;
              issue(pc_q, 1'b1, 1'b0, 8'h00);
            end
            `CTTSW_OP_S2X: begin
              {h_q, x_q} <= sp_q + 16'h0001;
              step_q <= 4'd0;
              issue(pc_q, 1'b1, 1'b0, 8'h00);
            end
            `CTTSW_OP_X2S: begin
              sp_q <= hx - 16'h0001;
              step_q <= 4'd0;
              issue(pc_q, 1'b1, 1'b0, 8'h00);
            end
            `CTTSW_OP_TSTD, `CTTSW_OP_TSTI1: begin
              if (step_q == 4'd1) begin
                pc_q <= pc_inc;
                if (op_q == `CTTSW_OP_TSTD)
                  issue({8'h00, MEM_RDATA}, 1'b1, 1'b0, 8'h00);
                else
                  issue(hx + {8'h00, MEM_RDATA}, 1'b1, 1'b0, 8'h00);
              end else begin
                test_flags;
                step_q <= 4'd0;
                issue(pc_q, 1'b1, 1'b0, 8'h00);
              end
            end
            `CTTSW_OP_TSTI: begin
              test_flags;
              step_q <= 4'd0;
              issue(pc_q, 1'b1, 1'b0, 8'h00);
            end
            `CTTSW_OP_PFX: begin
              case (step_q)
                4'd1: begin
                  pc_q <= pc_inc;
                  if (MEM_RDATA == `CTTSW_OP_TSTI1) begin
                    issue(pc_inc, 1'b1, 1'b0, 8'h00);
                  end else begin
                    ill_q <= 1'b1;
                    step_q <= 4'd0;
                    issue(pc_inc, 1'b1, 1'b0, 8'h00);
                  end
                end
                4'd2: begin
                  pc_q <= pc_inc;
                  issue(sp_q + {8'h00, MEM_RDATA}, 1'b1, 1'b0, 8'h00);
                end
                default: begin
                  test_flags;
                  step_q <= 4'd0;
                  issue(pc_q, 1'b1, 1'b0, 8'h00);
                end
              endcase
            end
            `CTTSW_OP_LDAE: begin
              case (step_q)
                4'd1: begin
                  tmp_q <= MEM_RDATA;
                  pc_q <= pc_inc;
                  issue(pc_inc, 1'b1, 1'b0, 8'h00);
                end
                4'd2: begin
                  pc_q <= pc_inc;
                  issue({tmp_q, MEM_RDATA}, 1'b1, 1'b0, 8'h00);
                end
                default: begin
                  acc_q <= MEM_RDATA;
                  test_flags;
                  step_q <= 4'd0;
                  issue(pc_q, 1'b1, 1'b0, 8'h00);
                end
              endcase
            end
            `CTTSW_OP_MOVPI: begin
              case (step_q)
                4'd1: begin
                  tmp_q <= MEM_RDATA;
                  test_flags;
                  issue(pc_q, 1'b1, 1'b0, 8'h00);
                end
                4'd2: begin
                  pc_q <= pc_inc;
                  issue({8'h00, MEM_RDATA}, 1'b0, 1'b1, tmp_q);
                end
                default: begin
                  step_q <= 4'd0;
                  issue(pc_q, 1'b1, 1'b0, 8'h00);
                end
              endcase
            end
            `CTTSW_OP_TRAP: begin
              case (step_q)
                4'd1: issue(sp_q, 1'b0, 1'b1, pc_q[7:0]);
                4'd2: issue(sp_q - 16'h0001, 1'b0, 1'b1, pc_q[15:8]);
                4'd3: issue(sp_q - 16'h0002, 1'b0, 1'b1, x_q);
                4'd4: issue(sp_q - 16'h0003, 1'b0, 1'b1, acc_q);
                4'd5: issue(sp_q - 16'h0004, 1'b0, 1'b1, flags_q);
                4'd6: begin
                  sp_q <= sp_q - 16'h0005;
                  flags_q[`CTTSW_FLG_I] <= 1'b1;
                  issue(`CTTSW_VEC_HI, 1'b1, 1'b0, 8'h00);
                end
                4'd7: begin
                  tmp_q <= MEM_RDATA;
                  issue(`CTTSW_VEC_LO, 1'b1, 1'b0, 8'h00);
                end
                default: begin
                  pc_q <= {tmp_q, MEM_RDATA};
                  step_q <= 4'd0;
                  issue({tmp_q, MEM_RDATA}, 1'b1, 1'b0, 8'h00);
                end
              endcase
            end
            default: begin
              step_q <= 4'd0;
              issue(pc_q, 1'b1, 1'b0, 8'h00);
            end
          endcase
        end
      end
    end
  end
endmodule

/* File: hw/cttsw_regs.vh */
// Purpose: Constants for the transfer, test, trap and wait execute block.
// Assumes: Included by cttsw_core and the test bench.
// Notes: Offsets are APB byte addresses of 32-bit words.
`ifndef CTTSW_REGS_VH
`define CTTSW_REGS_VH

`define CTTSW_OFF_CTRL 8'h00
`define CTTSW_OFF_STAT 8'h04
`define CTTSW_OFF_ACC 8'h08
`define CTTSW_OFF_XLO 8'h0c
`define CTTSW_OFF_XHI 8'h10
`define CTTSW_OFF_SP 8'h14
`define CTTSW_OFF_PC 8'h18
`define CTTSW_OFF_FLAGS 8'h1c

`define CTTSW_CTRL_RUN 0
`define CTTSW_STAT_WAIT 0
`define CTTSW_STAT_ILL 1
`define CTTSW_STAT_BUSY 2

`define CTTSW_FLG_V 7
`define CTTSW_FLG_H 4
`define CTTSW_FLG_I 3
`define CTTSW_FLG_N 2
`define CTTSW_FLG_Z 1
`define CTTSW_FLG_C 0
`define CTTSW_FLG_ONES 8'h60

`define CTTSW_RST_ACC 8'h00
`define CTTSW_RST_X 8'h00
`define CTTSW_RST_H 8'h00
`define CTTSW_RST_SP 16'h00ff
`define CTTSW_RST_PC 16'h0000
`define CTTSW_RST_FLAGS 8'h68

`define CTTSW_VEC_HI 16'hfffc
`define CTTSW_VEC_LO 16'hfffd

`define CTTSW_OP_TRAP 8'h83
`define CTTSW_OP_A2F 8'h84
`define CTTSW_OP_F2A 8'h85
`define CTTSW_OP_WAIT 8'h8f
`define CTTSW_OP_X2S 8'h94
`define CTTSW_OP_S2X 8'h95
`define CTTSW_OP_A2X 8'h97
`define CTTSW_OP_X2A 8'h9f
`define CTTSW_OP_TSTD 8'h3d
`define CTTSW_OP_TSTA 8'h4d
`define CTTSW_OP_TSTX 8'h5d
`define CTTSW_OP_TSTI1 8'h6d
`define CTTSW_OP_TSTI 8'h7d
`define CTTSW_OP_PFX 8'h9e
`define CTTSW_OP_LDAE 8'hc6
`define CTTSW_OP_MOVPI 8'h7e

`endif

/* File: hw/cttsw_nz.v */
// Purpose: Negative and zero flags of a byte compared with zero.
// Assumes: Purely combinational.
// Notes: Subtracting zero never borrows, so only sign and zero matter.
`timescale 1ns/10ps
module cttsw_nz (
  input wire [7:0] val,
  output wire neg,
  output wire zero
);
  assign neg = val[7];
  assign zero = (val == 8'h00);
endmodule

/* File: sim/cttsw_assertions.sv */
// Purpose: Port-level checks for the trap, wait and register access behaviour.
// Assumes: Bound to cttsw_core; one clock domain.
// Notes: Trap checks assume CE stays high while a trap runs.
`timescale 1ns/10ps
module cttsw_assertions (
  input wire MCLK,
  input wire RST,
  input wire CE,
  input wire IRQ,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [15:0] MEM_ADDR,
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [7:0] MEM_RDATA,
  input wire CORE_CLK_EN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire acc = PSEL && PENABLE;
  wire bad = (PADDR > 8'h1c) || (PADDR[1:0] != 2'b00);
  a_vec_order:
  assert property ((CE && MEM_RD && MEM_ADDR == 16'hfffc) |=> (MEM_RD && MEM_ADDR == 16'hfffd)
    ##1 (MEM_RD && MEM_ADDR == {$past(MEM_RDATA, 2), $past(MEM_RDATA)}))
    else $error("trap vector fetch wrong");
  a_push_descend:
  assert property ((CE && $past(CE) && MEM_WR && $past(MEM_WR)) |->
    MEM_ADDR == $past(MEM_ADDR) - 16'h0001) else $error("stack push not descending");
  a_push_run:
  assert property (!MEM_WR ##1 (CE && MEM_WR) ##1 (CE && MEM_WR) |=> MEM_WR [*3]
    ##1 (MEM_RD && MEM_ADDR == 16'hfffc)) else $error("trap push run wrong");
  a_halt_idle:
  assert property (!CORE_CLK_EN |-> !MEM_RD && !MEM_WR) else $error("bus busy while halted");
  a_irq_wake:
  assert property ((!CORE_CLK_EN && IRQ && CE) |-> ##[1:2] CORE_CLK_EN)
    else $error("interrupt did not wake core");
  a_ready_ce:
  assert property (PREADY == CE) else $error("ready does not follow enable");
  a_err_bad:
  assert property ((acc && bad && !PWRITE) |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped read not refused");
  a_err_good:
  assert property ((acc && !bad) |-> !PSLVERR) else $error("mapped access refused");
  c_trap: cover property ((CE && MEM_RD && MEM_ADDR == 16'hfffd));
  c_wake: cover property ((!CORE_CLK_EN && IRQ));
  c_bad: cover property ((acc && bad));
endmodule
bind cttsw_core cttsw_assertions i_chk (.MCLK(MCLK), .RST(RST), .CE(CE), .IRQ(IRQ), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
  .MEM_RDATA(MEM_RDATA), .CORE_CLK_EN(CORE_CLK_EN));

/* File: sim/cttsw_mem.sv */
// Purpose: Memory seen by the execute block.
// Assumes: Reads answer combinationally, writes land at the clock edge.
// Notes: The bench preloads bytes through the array m.
`timescale 1ns/10ps
module cttsw_mem (
  input wire mclk,
  input wire [15:0] addr,
  input wire rd,
  input wire wr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  logic [7:0] m [0:65535];
  logic [7:0] last_q;
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 65536; i++) m[i] = 8'h00;
  end
  // An idle bus shows the inverted last byte so stale data cannot pass as valid.
  assign rdata = rd ? m[addr] : ~last_q;
  always @(posedge mclk) begin
    if (rd) last_q <= m[addr];
    if (wr) m[addr] <= wdata;
  end
endmodule

/* File: sim/test_cpu_transfer_test_swi_wait_ops.sv */
// Purpose: Self-checking bench for the execute block.
// Assumes: Each program ends in a wait, which marks its end.
// Notes: Cycle counts are measured against a lone wait.
`timescale 1ns/10ps
`include "cttsw_regs.vh"
module test_cpu_transfer_test_swi_wait_ops;
  logic MCLK = 0, RST = 1, CE = 1, IRQ = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, MEM_RD, MEM_WR, CORE_CLK_EN, err;
  logic [15:0] MEM_ADDR;
  logic [7:0] MEM_WDATA, MEM_RDATA;
  logic [39:0] stk = 40'h0100223360;
  int n_fail = 0, checked = 0, cyc = 0, n, base;
  logic [87:0] rows [14] = '{88'h8f8f8f000060000060f000, 88'h4d8f8f8000f9800075f001,
    88'h5d8f8f0000ec000062f001, 88'h3df68f010060010062f003, 88'h9e6d05000062000064f004,
    88'h978f8f5a006b5a5a63f001, 88'h9f8f8f00a56aa5a562f001, 88'h858f8f00006d6d0065f001,
    88'h848f8f9700609700f7f002, 88'h958f8f00006100f161f002, 88'h948f8f0020600020601f02,
    88'hc600f5000062800064f004, 88'h7e308f00f56400f664f004, 88'h838f8f332260332260eb09};
  always #50 MCLK = ~MCLK;
  cttsw_core i_dut (.MCLK(MCLK), .RST(RST), .CE(CE), .IRQ(IRQ), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .CORE_CLK_EN(CORE_CLK_EN));
  cttsw_mem i_mem (.mclk(MCLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR), .wdata(MEM_WDATA),
    .rdata(MEM_RDATA));
  task conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude;
    end
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) @(posedge MCLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task run_row(input logic [87:0] r);
    apb(1, `CTTSW_OFF_CTRL, 0);
    for (int i = 0; i < 3; i++) i_mem.m[i] = r[87-8*i -: 8];
    apb(1, `CTTSW_OFF_PC, 0);
    apb(1, `CTTSW_OFF_ACC, 32'(r[63:56]));
    apb(1, `CTTSW_OFF_XLO, 32'(r[55:48]));
    apb(1, `CTTSW_OFF_FLAGS, 32'(r[47:40]));
    apb(1, `CTTSW_OFF_SP, 32'h00f0);
    apb(1, `CTTSW_OFF_CTRL, 1);
    n = 0;
    while (CORE_CLK_EN !== 1'b0) begin
      @(posedge MCLK);
      n++;
    end
    IRQ <= 1;
    while (CORE_CLK_EN !== 1'b1) @(posedge MCLK);
    IRQ <= 0;
    while (CORE_CLK_EN !== 1'b0) @(posedge MCLK);
    apb(1, `CTTSW_OFF_CTRL, 0);
    apb(0, `CTTSW_OFF_ACC, 0);
    chk("acc", 32'(r[39:32]), rd);
    apb(0, `CTTSW_OFF_XLO, 0);
    chk("xlo", 32'(r[31:24]), rd);
    apb(0, `CTTSW_OFF_FLAGS, 0);
    chk("flags", 32'(r[23:16]), rd);
    apb(0, `CTTSW_OFF_SP, 0);
    chk("sp", 32'(r[15:8]), rd);
  endtask
  initial begin
    repeat (16) @(posedge MCLK);
    RST <= 0;
    i_mem.m[16'hfffd] = 8'h40;
    i_mem.m[16'h40] = 8'h8f;
    i_mem.m[16'h41] = 8'h8f;
    i_mem.m[3] = 8'h8f;
    i_mem.m[4] = 8'h8f;
    i_mem.m[16'hf5] = 8'h80;
    apb(0, `CTTSW_OFF_SP, 0);
    chk("sp reset", 32'h00ff, rd);
    apb(0, `CTTSW_OFF_FLAGS, 0);
    chk("flags reset", 32'h0068, rd);
    for (int i = 0; i < 14; i++) begin
      run_row(rows[i]);
      if (i == 0) base = n;
      else chk("cycles", base + rows[i][7:0], n);
    end
    for (int i = 0; i < 5; i++) chk("stack", 32'(stk[39-8*i -: 8]), 32'(i_mem.m[16'hf0 - i]));
    apb(0, `CTTSW_OFF_PC, 0);
    chk("pc", 32'h0042, rd);
    chk("movdst", 32'h80, 32'(i_mem.m[16'h30]));
    apb(0, 8'h40, 0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped rd", 32'h0, rd);
    CE <= 0;
    @(posedge MCLK);
    chk("ready", 32'h0, 32'(PREADY));
    CE <= 1;
    conclude;
  end
endmodule
